// >>> rtl/ptt_trip_timer.sv
// trip and release timing, events, counters and fault records
`timescale 1ns/1ns
`default_nettype none
module ptt_trip_timer
   import ptt_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int REC_N = REC_DEPTH
)
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic [RATIO_W-1:0] MEAS_RATIO_IN,
   input wire logic BLOCK_IN,
   input wire logic DELAY_MODE_IN,
   input wire logic [FIXED_W-1:0] FIXED_DELAY_IN,
   input wire logic [DIAL_W-1:0] TIME_DIAL_IN,
   input wire logic [EXP_W-1:0] EXPONENT_IN,
   input wire logic [REL_W-1:0] RELEASE_DELAY_IN,
   input wire logic DELAYED_RELEASE_EN_IN,
   input wire logic TIMER_RESET_AFTER_REL_IN,
   input wire logic CONTINUE_DURING_REL_IN,
   input wire logic [2:0] EVT_ON_EN_IN,
   input wire logic [2:0] EVT_OFF_EN_IN,
   input wire logic [STAMP_W-1:0] TIMESTAMP_IN,
   input wire logic [GROUP_W-1:0] SETTING_GROUP_IN,
   input wire logic COUNTER_CLEAR_IN,
   input wire logic [3:0] REC_INDEX_IN,
   output logic PICKUP_OUT,
   output logic START_OUT,
   output logic TRIP_OUT,
   output logic BLOCKED_OUT,
   output logic [FIXED_W-1:0] TIME_REMAIN_OUT,
   output logic [2:0] EVT_ON_OUT,
   output logic [2:0] EVT_OFF_OUT,
   output logic [STAMP_W-1:0] EVT_TIME_OUT,
   output logic [CNT_W-1:0] START_CNT_OUT,
   output logic [CNT_W-1:0] TRIP_CNT_OUT,
   output logic [CNT_W-1:0] BLOCK_CNT_OUT,
   output logic REC_VALID_OUT,
   output logic [STAMP_W-1:0] REC_TIME_OUT,
   output logic [1:0] REC_EVENT_OUT,
   output logic [RATIO_W-1:0] REC_PRE20_OUT,
   output logic [RATIO_W-1:0] REC_FAULT_OUT,
   output logic [RATIO_W-1:0] REC_PRE200_OUT,
   output logic [FIXED_W-1:0] REC_REMAIN_OUT,
   output logic [GROUP_W-1:0] REC_GROUP_OUT
);
   logic [16:0] tick_cnt, next_tick_cnt;
   logic tick, next_tick;
   logic pu, next_pu;
   logic [RATIO_W-1:0] hist [0:PRE200_TICKS-1];
   logic [RATIO_W-1:0] next_hist [0:PRE200_TICKS-1];
   ptt_state_e st, next_st;
   logic [FIXED_W-1:0] op_cnt, next_op_cnt, tgt, fixed_dly, inverse_delay_mode_ticks, next_remain;
   logic [REL_W-1:0] rel_cnt, next_rel_cnt, rel_dly;
   logic next_start, next_trip, next_blk;
   logic [2:0] cur_flags, new_flags, ev_on, ev_off;
   logic [CNT_W-1:0] cnt [0:2];
   logic [CNT_W-1:0] next_cnt [0:2];

   // 5 ms tick shared by every delay
   always_comb
   begin
      next_tick = (tick_cnt == 17'(TICK_CYC - 1));
      next_tick_cnt = next_tick ? 17'h00000 : tick_cnt + 17'h00001;
   end

   // under-type element: picks up below unity, drops at 103 percent
   always_comb
   begin
      next_pu = pu ? (MEAS_RATIO_IN < RATIO_RELEASE) : (MEAS_RATIO_IN < RATIO_UNITY);
      for (int i = 0; i < PRE200_TICKS; i++)
         next_hist[i] = hist[i];
      if (tick)
      begin
         next_hist[0] = MEAS_RATIO_IN;
         for (int i = 1; i < PRE200_TICKS; i++)
            next_hist[i] = hist[i-1];
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         tick_cnt <= 17'h00000;
         tick <= 1'b0;
         pu <= 1'b0;
         for (int i = 0; i < PRE200_TICKS; i++)
            hist[i] <= 17'h00000;
      end
      else
      begin
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
         pu <= next_pu;
         for (int i = 0; i < PRE200_TICKS; i++)
            hist[i] <= next_hist[i];
      end
   end

   ptt_inverse_delay_mode_calc u_inverse_delay_mode (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .ratio_in(MEAS_RATIO_IN),
      .dial_in(TIME_DIAL_IN),
      .exp_in(EXPONENT_IN),
      .ticks_out(inverse_delay_mode_ticks)
   );

   // timing state machine
   always_comb
   begin
      fixed_dly = (FIXED_DELAY_IN > FIXED_MAX) ? FIXED_MAX : FIXED_DELAY_IN;
      rel_dly = (RELEASE_DELAY_IN > REL_MAX) ? REL_MAX : RELEASE_DELAY_IN;
      tgt = (DELAY_MODE_IN == MODE_FIXED) ? fixed_dly : inverse_delay_mode_ticks;
      next_st = st;
      next_op_cnt = op_cnt;
      next_rel_cnt = rel_cnt;
      case (st)
         PTT_IDLE:
         begin
            next_op_cnt = '0;
            if (pu)
               next_st = BLOCK_IN ? PTT_BLK : PTT_RUN;
         end
         PTT_RUN:
         begin
            if (BLOCK_IN)
            begin
               // late block still wins, even after expiry with trip already set
               next_st = PTT_BLK;
               next_op_cnt = '0;
            end
            else if (!pu)
            begin
               if (TRIP_OUT || rel_dly == '0)
               begin
                  next_st = PTT_IDLE;
                  next_op_cnt = '0;
               end
               else
               begin
                  next_st = PTT_REL;
                  next_rel_cnt = '0;
                  if (!TIMER_RESET_AFTER_REL_IN && !CONTINUE_DURING_REL_IN)
                     next_op_cnt = '0;
               end
            end
            else if (tick && op_cnt < tgt)
               next_op_cnt = op_cnt + 19'h00001;
         end
         PTT_REL:
         begin
            if (pu)
               next_st = BLOCK_IN ? PTT_BLK : PTT_RUN;
            else if (tick)
            begin
               next_rel_cnt = rel_cnt + 15'h0001;
               if (CONTINUE_DURING_REL_IN && op_cnt < FIXED_MAX)
                  next_op_cnt = op_cnt + 19'h00001;
               if (next_rel_cnt >= rel_dly)
               begin
                  next_st = PTT_IDLE;
                  next_op_cnt = '0;
               end
            end
         end
         PTT_BLK:
         begin
            next_op_cnt = '0;
            if (!pu)
               next_st = PTT_IDLE;
         end
         default:
         begin
            next_st = PTT_IDLE;
            next_op_cnt = '0;
         end
      endcase
      next_blk = (next_st == PTT_BLK);
      next_start = (next_st == PTT_RUN) || (next_st == PTT_REL && DELAYED_RELEASE_EN_IN);
      // zero target trips with start in the same cycle
      next_trip = (next_st == PTT_RUN) && (next_op_cnt >= tgt);
      next_remain = ((next_st == PTT_RUN || next_st == PTT_REL) && tgt > next_op_cnt) ?
         tgt - next_op_cnt : 19'h00000;
   end

   // events and counters; a count on the clear cycle is kept
   always_comb
   begin
      cur_flags = {BLOCKED_OUT, TRIP_OUT, START_OUT};
      new_flags = {next_blk, next_trip, next_start};
      ev_on = new_flags & ~cur_flags;
      ev_off = cur_flags & ~new_flags;
      for (int i = 0; i < 3; i++)
         next_cnt[i] = (COUNTER_CLEAR_IN ? '0 : cnt[i]) + CNT_W'(ev_on[i]);
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         st <= PTT_IDLE;
         op_cnt <= '0;
         rel_cnt <= '0;
         PICKUP_OUT <= 1'b0;
         START_OUT <= 1'b0;
         TRIP_OUT <= 1'b0;
         BLOCKED_OUT <= 1'b0;
         TIME_REMAIN_OUT <= '0;
         EVT_ON_OUT <= 3'h0;
         EVT_OFF_OUT <= 3'h0;
         EVT_TIME_OUT <= '0;
         for (int i = 0; i < 3; i++)
            cnt[i] <= '0;
      end
      else
      begin
         st <= next_st;
         op_cnt <= next_op_cnt;
         rel_cnt <= next_rel_cnt;
         PICKUP_OUT <= next_pu;
         START_OUT <= next_start;
         TRIP_OUT <= next_trip;
         BLOCKED_OUT <= next_blk;
         TIME_REMAIN_OUT <= next_remain;
         EVT_ON_OUT <= ev_on & EVT_ON_EN_IN;
         EVT_OFF_OUT <= ev_off & EVT_OFF_EN_IN;
         EVT_TIME_OUT <= TIMESTAMP_IN;
         for (int i = 0; i < 3; i++)
            cnt[i] <= next_cnt[i];
      end
   end

   assign START_CNT_OUT = cnt[EV_START];
   assign TRIP_CNT_OUT = cnt[EV_TRIP];
   assign BLOCK_CNT_OUT = cnt[EV_BLOCK];

   // fault record ring; trip outranks block outranks start
   logic [STAMP_W-1:0] rec_time [0:REC_N-1];
   logic [1:0] rec_ev [0:REC_N-1];
   logic [RATIO_W-1:0] rec_pre20 [0:REC_N-1];
   logic [RATIO_W-1:0] rec_fault [0:REC_N-1];
   logic [RATIO_W-1:0] rec_pre200 [0:REC_N-1];
   logic [FIXED_W-1:0] rec_remain [0:REC_N-1];
   logic [GROUP_W-1:0] rec_grp [0:REC_N-1];
   logic [3:0] wp, next_wp, rcount, next_rcount, rd;
   logic rec_we;
   ptt_event_e rec_code;
   int ri;

   always_comb
   begin
      ri = 0;
      rec_we = |ev_on;
      rec_code = ev_on[EV_TRIP] ? PTT_EV_TRIP : ev_on[EV_BLOCK] ? PTT_EV_BLOCK : PTT_EV_START;
      next_wp = wp;
      next_rcount = rcount;
      if (rec_we)
      begin
         next_wp = (wp == 4'(REC_N - 1)) ? 4'h0 : wp + 4'h1;
         if (rcount < 4'(REC_N))
            next_rcount = rcount + 4'h1;
      end
      ri = int'(wp) - 1 - int'(REC_INDEX_IN);
      if (ri < 0)
         ri = ri + REC_N;
      if (ri < 0)
         ri = 0;
      rd = 4'(ri);
   end

   always_ff @(posedge CLK_IN)
   begin
      if (rec_we)
      begin
         rec_time[wp] <= TIMESTAMP_IN;
         rec_ev[wp] <= rec_code;
         rec_pre20[wp] <= hist[PRE20_TICKS-1];
         rec_fault[wp] <= MEAS_RATIO_IN;
         rec_pre200[wp] <= hist[PRE200_TICKS-1];
         rec_remain[wp] <= next_remain;
         rec_grp[wp] <= SETTING_GROUP_IN;
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         wp <= 4'h0;
         rcount <= 4'h0;
         REC_VALID_OUT <= 1'b0;
         REC_TIME_OUT <= '0;
         REC_EVENT_OUT <= PTT_EV_NONE;
         REC_PRE20_OUT <= '0;
         REC_FAULT_OUT <= '0;
         REC_PRE200_OUT <= '0;
         REC_REMAIN_OUT <= '0;
         REC_GROUP_OUT <= '0;
      end
      else
      begin
         wp <= next_wp;
         rcount <= next_rcount;
         REC_VALID_OUT <= (REC_INDEX_IN < rcount);
         REC_TIME_OUT <= rec_time[rd];
         REC_EVENT_OUT <= rec_ev[rd];
         REC_PRE20_OUT <= rec_pre20[rd];
         REC_FAULT_OUT <= rec_fault[rd];
         REC_PRE200_OUT <= rec_pre200[rd];
         REC_REMAIN_OUT <= rec_remain[rd];
         REC_GROUP_OUT <= rec_grp[rd];
      end
   end

   property p_instant;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (st == PTT_IDLE && pu && !BLOCK_IN && DELAY_MODE_IN == MODE_FIXED
       && FIXED_DELAY_IN == 19'h00000) |=> (START_OUT && TRIP_OUT);
   endproperty
   a_instant: assert property (p_instant) else $error("instant trip missing");

   property p_fixed;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (st == PTT_RUN && pu && !BLOCK_IN && DELAY_MODE_IN == MODE_FIXED
       && op_cnt >= fixed_dly) |=> TRIP_OUT;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed delay trip missing");

   property p_no_trip_early;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      TRIP_OUT |-> ($past(pu) && op_cnt >= $past(tgt));
   endproperty
   a_no_trip_early: assert property (p_no_trip_early) else $error("trip without cause");

   property p_release_off;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (!pu && !DELAYED_RELEASE_EN_IN) |=> !START_OUT;
   endproperty
   a_release_off: assert property (p_release_off) else $error("start held");

   property p_reset_at_drop;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (st == PTT_RUN && !pu && !BLOCK_IN && !TIMER_RESET_AFTER_REL_IN
       && !CONTINUE_DURING_REL_IN) |=> (op_cnt == '0);
   endproperty
   a_reset_at_drop: assert property (p_reset_at_drop) else $error("timer kept");

   property p_continue;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (st == PTT_REL && !pu && tick && CONTINUE_DURING_REL_IN && op_cnt < FIXED_MAX
       && rel_cnt + 15'h0001 < rel_dly) |=> (op_cnt == $past(op_cnt) + 19'h00001);
   endproperty
   a_continue: assert property (p_continue) else $error("release count stalled");

   property p_blocked;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (st == PTT_IDLE && pu && BLOCK_IN) |=> (BLOCKED_OUT && !START_OUT && !TRIP_OUT)
         ##1 (op_cnt == '0);
   endproperty
   a_blocked: assert property (p_blocked) else $error("block ignored");

   property p_count;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (ev_on[EV_TRIP] && !COUNTER_CLEAR_IN) |=> (TRIP_CNT_OUT == $past(TRIP_CNT_OUT) + 16'h0001);
   endproperty
   a_count: assert property (p_count) else $error("trip count wrong");

   property p_filter;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (ev_off[EV_START] && !EVT_OFF_EN_IN[EV_START]) |=> !EVT_OFF_OUT[EV_START];
   endproperty
   a_filter: assert property (p_filter) else $error("filtered event passed");

   property p_ring;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (rcount <= 4'(REC_N)) && (wp < 4'(REC_N));
   endproperty
   a_ring: assert property (p_ring) else $error("record ring out of range");

   property p_hyst;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (pu && MEAS_RATIO_IN < RATIO_RELEASE) |=> pu;
   endproperty
   a_hyst: assert property (p_hyst) else $error("pick-up dropped early");
endmodule : ptt_trip_timer
`default_nettype wire

// >>> rtl/ptt_pkg.sv
// constants and types shared by the protection trip timer
package ptt_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_TIME_NS = 5000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int RATIO_W = 17;
   localparam int FIXED_W = 19;
   localparam int DIAL_W = 13;
   localparam int EXP_W = 12;
   localparam int REL_W = 15;
   localparam int STAMP_W = 48;
   localparam int CNT_W = 16;
   localparam int GROUP_W = 3;
   localparam int REC_DEPTH = 12;
   localparam int PRE20_TICKS = 4;
   localparam int PRE200_TICKS = 40;
   // settings in 5 ms ticks, dial in 10 ms units, exponent in hundredths
   localparam logic [18:0] FIXED_MAX = 19'h57E40;
   localparam logic [18:0] FIXED_DEFAULT = 19'h00008;
   localparam logic [14:0] REL_MAX = 15'h7530;
   localparam logic [14:0] REL_DEFAULT = 15'h000C;
   localparam logic [12:0] DIAL_MIN = 13'h0001;
   localparam logic [12:0] DIAL_MAX = 13'h1770;
   localparam logic [12:0] DIAL_DEFAULT = 13'h0005;
   localparam logic [11:0] EXP_MIN = 12'h001;
   localparam logic [11:0] EXP_MAX = 12'h9C4;
   localparam logic [11:0] EXP_DEFAULT = 12'h064;
   // ratio measured/pick-up in hundredths
   localparam logic [16:0] RATIO_UNITY = 17'h00064;
   localparam logic [16:0] RATIO_RELEASE = 17'h00067;
   localparam logic [13:0] LOG2_100_Q8 = 14'h06A5;
   localparam logic [39:0] DIV100_Q16 = 40'h000000028F;
   localparam logic [9:0] ONE_Q9 = 10'h200;
   localparam int EV_START = 0;
   localparam int EV_TRIP = 1;
   localparam int EV_BLOCK = 2;
   localparam logic MODE_FIXED = 1'b0;
   typedef enum logic [1:0] {
      PTT_IDLE = 2'b00,
      PTT_RUN = 2'b01,
      PTT_REL = 2'b10,
      PTT_BLK = 2'b11
   } ptt_state_e;
   typedef enum logic [1:0] {
      PTT_EV_NONE = 2'b00,
      PTT_EV_START = 2'b01,
      PTT_EV_TRIP = 2'b10,
      PTT_EV_BLOCK = 2'b11
   } ptt_event_e;
endpackage : ptt_pkg

// >>> rtl/ptt_inverse_delay_mode_calc.sv
// inverse-time operating delay, registered, in 5 ms ticks
`timescale 1ns/1ns
`default_nettype none
module ptt_inverse_delay_mode_calc
   import ptt_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [RATIO_W-1:0] ratio_in,
   input wire logic [DIAL_W-1:0] dial_in,
   input wire logic [EXP_W-1:0] exp_in,
   output logic [FIXED_W-1:0] ticks_out
);
   function automatic logic [4:0] msb_pos(input logic [16:0] v);
      logic [4:0] p;
      p = 5'h00;
      for (int i = 0; i < 17; i++)
      begin
         if (v[i])
            p = 5'(i);
      end
      return p;
   endfunction : msb_pos

   logic [16:0] x, norm;
   logic [4:0] p;
   logic [12:0] dial;
   logic [11:0] expo;
   logic signed [13:0] lg;
   logic signed [39:0] prod;
   logic signed [23:0] y;
   logic signed [15:0] yi;
   logic [23:0] mant;
   logic [47:0] wide;
   logic [FIXED_W-1:0] next_ticks;

   // log2 and exp2 are piecewise linear; error reaches over ten percent at exponent 1.00 and grows with the exponent
   always_comb
   begin
      x = (ratio_in >= RATIO_UNITY) ? ratio_in - RATIO_UNITY : RATIO_UNITY - ratio_in;
      if (x == 17'h00000)
         x = 17'h00001;
      dial = (dial_in < DIAL_MIN) ? DIAL_MIN : (dial_in > DIAL_MAX) ? DIAL_MAX : dial_in;
      expo = (exp_in < EXP_MIN) ? EXP_MIN : (exp_in > EXP_MAX) ? EXP_MAX : exp_in;
      p = msb_pos(x);
      norm = x << (5'd16 - p);
      lg = signed'({1'b0, p, norm[15:8]}) - signed'(LOG2_100_Q8);
      prod = 40'(lg) * 40'(signed'({1'b0, expo})) * signed'(DIV100_Q16);
      y = 24'(prod >>> 16);
      yi = 16'(y >>> 8);
      mant = (24'({dial, 1'b0}) * 24'(ONE_Q9 - {2'b00, y[7:0]})) >> 9;
      wide = 48'h000000000000;
      next_ticks = FIXED_MAX;
      if (yi >= 0)
      begin
         if (yi < 16'sd24)
            next_ticks = 19'(mant >> yi[4:0]);
         else
            next_ticks = 19'h00000;
      end
      else if (yi > -16'sd20)
      begin
         wide = 48'(mant) << 5'(-yi);
         if (wide <= 48'(FIXED_MAX))
            next_ticks = 19'(wide);
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         ticks_out <= FIXED_DEFAULT;
      else
         ticks_out <= next_ticks;
   end
endmodule : ptt_inverse_delay_mode_calc
`default_nettype wire

// >>> test/ptt_source_model.sv
// pick-up side model: ratio, blocking level and time stamp
`timescale 1ns/1ns
`default_nettype none
module ptt_source_model
   import ptt_pkg::*;
(
   input wire logic clk_in,
   input wire logic [1:0] mode_in,
   input wire logic blk_in,
   input wire logic [31:0] rnd_in,
   input wire logic [STAMP_W-1:0] stamp_in,
   output logic [RATIO_W-1:0] ratio_out,
   output logic block_out,
   output logic [STAMP_W-1:0] stamp_out
);
   // ratio jitters every cycle in modes 0 to 2; mode 3 holds a steady 50
   always_ff @(posedge clk_in)
   begin
      case (mode_in)
         2'h0: ratio_out <= RATIO_W'(32'h67 + rnd_in % 32'hC8);
         2'h1: ratio_out <= RATIO_W'(32'h1 + rnd_in % 32'h63);
         2'h2: ratio_out <= RATIO_W'(32'h64 + rnd_in % 32'h3);
         default: ratio_out <= 17'h00032;
      endcase
      block_out <= blk_in;
      stamp_out <= stamp_in;
   end
endmodule : ptt_source_model
`default_nettype wire

// >>> test/tb_ptt_trip_timer.sv
// self-checking bench for the protection trip timer
`timescale 1ns/1ns
`default_nettype none
module tb_ptt_trip_timer
   import ptt_pkg::*;
;
   localparam int TC = 10;
   logic clk = 1'b0;
   logic rst_b, blk, dmode, drel, trst, cont, clr, blk_w, pu, st, tr, bo, rv;
   logic [1:0] mode, re;
   logic [FIXED_W-1:0] fixed;
   logic [DIAL_W-1:0] dial;
   logic [EXP_W-1:0] expo;
   logic [REL_W-1:0] rel;
   logic [2:0] on_en, off_en, ev_on, ev_off;
   logic [STAMP_W-1:0] stamp, ts, ev_t, rt;
   logic [GROUP_W-1:0] grp, rg;
   logic [3:0] idx;
   logic [31:0] seed;
   logic [RATIO_W-1:0] ratio;
   logic [CNT_W-1:0] sc, tc, bc;
   logic [FIXED_W-1:0] rem, rrem;
   logic [RATIO_W-1:0] p20, rf, p200;
   int fail_count, cmp_count, n;
   logic [63:0] q[$];

   ptt_source_model u_src (.clk_in(clk), .mode_in(mode), .blk_in(blk), .rnd_in(seed),
      .stamp_in(stamp), .ratio_out(ratio), .block_out(blk_w), .stamp_out(ts));

   ptt_trip_timer #(.TICK_CYC(TC), .REC_N(REC_DEPTH)) dut (.CLK_IN(clk), .RST_B_IN(rst_b),
      .MEAS_RATIO_IN(ratio), .BLOCK_IN(blk_w), .DELAY_MODE_IN(dmode),
      .FIXED_DELAY_IN(fixed), .TIME_DIAL_IN(dial), .EXPONENT_IN(expo),
      .RELEASE_DELAY_IN(rel), .DELAYED_RELEASE_EN_IN(drel),
      .TIMER_RESET_AFTER_REL_IN(trst), .CONTINUE_DURING_REL_IN(cont),
      .EVT_ON_EN_IN(on_en), .EVT_OFF_EN_IN(off_en), .TIMESTAMP_IN(ts),
      .SETTING_GROUP_IN(grp), .COUNTER_CLEAR_IN(clr), .REC_INDEX_IN(idx),
      .PICKUP_OUT(pu), .START_OUT(st), .TRIP_OUT(tr), .BLOCKED_OUT(bo),
      .TIME_REMAIN_OUT(rem), .EVT_ON_OUT(ev_on), .EVT_OFF_OUT(ev_off), .EVT_TIME_OUT(ev_t),
      .START_CNT_OUT(sc), .TRIP_CNT_OUT(tc), .BLOCK_CNT_OUT(bc), .REC_VALID_OUT(rv),
      .REC_TIME_OUT(rt), .REC_EVENT_OUT(re), .REC_PRE20_OUT(p20), .REC_FAULT_OUT(rf),
      .REC_PRE200_OUT(p200), .REC_REMAIN_OUT(rrem), .REC_GROUP_OUT(rg));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      nxt = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : nxt

   always #25 clk = ~clk;
   always @(posedge clk) seed <= nxt(seed);

   task chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk

   task results;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc

   task note(input logic [2:0] on, input logic [2:0] off);
      q.push_back({10'h000, on, off, stamp});
   endtask : note

   // fresh stamp one edge ahead so it is stable when the event lands
   task go(input logic [1:0] m, input logic [2:0] on, input logic [2:0] off);
      @(posedge clk);
      stamp <= {16'h5A5A, seed};
      @(posedge clk);
      note(on, off);
      mode <= m;
   endtask : go

   task wt(input logic sel, output int k);
      k = 0;
      while (((sel ? tr : st) !== 1'b1) && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
   endtask : wt

   always @(negedge clk)
      if (rst_b === 1'b1 && (ev_on | ev_off) !== 3'h0)
      begin
         if (q.size() == 0)
            chk({10'h000, ev_on, ev_off, ev_t}, 64'h0);
         else
            chk({10'h000, ev_on, ev_off, ev_t}, q.pop_front());
      end

   initial
   begin
      #(40000 * 50);
      fail_count++;
      results();
   end

   initial
   begin
      {rst_b, blk, cont, clr, mode, stamp, idx, fail_count, cmp_count} = '0;
      {drel, trst, dmode, fixed, rel} = {2'h3, MODE_FIXED, 19'h0, REL_DEFAULT};
      {dial, expo, on_en, off_en, grp, seed} = {DIAL_DEFAULT, EXP_DEFAULT, 6'h3F, 3'h5, 32'h74666605};
      cyc(20);
      rst_b <= 1'b1;
      go(2'h1, 3'h3, 3'h0);
      cyc(6);
      #1;
      chk(tr, 1);
      chk(st, 1);
      chk({sc, tc}, 32'h00010001);
      chk({rv, re, rg}, {1'b1, 2'h2, grp});
      chk(rt, stamp);
      chk(rf < 17'h00064, 1);
      // no tick has shifted history yet, and an instant trip leaves nothing to run
      chk({p20, p200, rrem}, 0);
      go(2'h0, 3'h0, 3'h3);
      cyc(6);
      fixed <= 19'h4;
      rel <= 15'h0;
      go(2'h1, 3'h1, 3'h0);
      note(3'h2, 3'h0);
      wt(0, n);
      wt(1, n);
      chk(n >= 3 * TC && n <= 4 * TC + 1, 1);
      cyc(1);
      mode <= 2'h2;
      cyc(8);
      #1;
      chk(pu, 1);
      go(2'h0, 3'h0, 3'h3);
      cyc(6);
      for (int i = 1; i <= 2; i++)
      begin
         dmode <= 1'b1;
         fixed <= FIXED_MAX;
         expo <= 12'(100 * i);
         go(2'h3, 3'h1, 3'h0);
         note(3'h2, 3'h0);
         wt(0, n);
         wt(1, n);
         chk(n >= 17 * i * TC && n <= 23 * i * TC, 1);
         go(2'h0, 3'h0, 3'h3);
         cyc(6);
      end
      dmode <= MODE_FIXED;
      fixed <= 19'h14;
      rel <= 15'h6;
      go(2'h1, 3'h1, 3'h0);
      cyc(50);
      mode <= 2'h0;
      cyc(25);
      #1;
      chk(st, 1);
      chk(tr, 0);
      // four or five ticks ran before the drop, so 15 or 16 remain of 20
      chk(rem >= 19'h0000E && rem <= 19'h00010, 1);
      cyc(1);
      mode <= 2'h1;
      note(3'h2, 3'h0);
      wt(1, n);
      chk(n < 19 * TC, 1);
      go(2'h0, 3'h0, 3'h3);
      cyc(6);
      {cont, fixed, rel} <= {1'b1, 19'h8, 15'h14};
      go(2'h1, 3'h1, 3'h0);
      cyc(30);
      mode <= 2'h0;
      cyc(80);
      #1;
      chk(tr, 0);
      cyc(1);
      mode <= 2'h1;
      note(3'h2, 3'h0);
      wt(1, n);
      chk(n <= TC + 5, 1);
      go(2'h0, 3'h0, 3'h3);
      cyc(6);
      {cont, drel, trst, fixed, rel} <= {3'h0, 19'h14, 15'h6};
      go(2'h1, 3'h1, 3'h0);
      cyc(50);
      note(3'h0, 3'h1);
      mode <= 2'h0;
      cyc(6);
      #1;
      chk(st, 0);
      cyc(1);
      note(3'h1, 3'h0);
      note(3'h2, 3'h0);
      mode <= 2'h1;
      wt(0, n);
      wt(1, n);
      chk(n >= 19 * TC, 1);
      go(2'h0, 3'h0, 3'h3);
      cyc(6);
      {drel, trst, blk} <= 3'h7;
      go(2'h1, 3'h4, 3'h0);
      cyc(300);
      #1;
      chk({bo, st, tr}, 3'h4);
      chk({re, bc}, {2'h3, 16'h0001});
      go(2'h0, 3'h0, 3'h4);
      blk <= 1'b0;
      cyc(6);
      {fixed, on_en, off_en} <= {19'h0, 3'h2, 3'h1};
      go(2'h1, 3'h2, 3'h0);
      cyc(6);
      go(2'h0, 3'h0, 3'h1);
      cyc(6);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      cyc(2);
      #1;
      chk({sc, tc, bc}, 48'h0);
      chk(q.size(), 0);
      results();
   end
endmodule : tb_ptt_trip_timer
`default_nettype wire
